// *** testbench/ssf_spi_model.sv ***
// behavioural serial slave side: makes the link clock for whole bits
// assumes the bench calls send_bits only between frames
module ssf_spi_model (
    // serial clock toward the block
    output logic spi_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial spi_clk = 1'b0;
    // stands low between frames; odd start offset keeps phase unrelated
    task send_bits(input integer n);
        integer i;
        begin
            #7;
            for (i = 0; i < n; i = i + 1) begin
                #200 spi_clk = 1'b1;
                #200 spi_clk = 1'b0;
            end
        end
    endtask
endmodule

// *** testbench/ssf_status_assertions.sv ***
// concurrent checks on the bus and interrupt ports of the status block
// assumes the design header on the include path; bound into ssf_status
`include "ssf_regs.vh"
module ssf_status_chk (
    // clock and reset
    input wire clock,
    input wire reset,
    // register bus
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // interrupt
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire ar_go = s_axi_arvalid && s_axi_arready;

    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped early");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    read_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    write_gate_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open during response");
    read_answer_a: assert property (ar_go |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> ##[0:2] s_axi_bvalid)
        else $error("write answer late");
    count_read_a: assert property (ar_go
        && s_axi_araddr == `SSF_OFF_COUNT |=> s_axi_rresp == `SSF_RESP_OKAY)
        else $error("count read refused");
    status_zero_a: assert property (ar_go
        && s_axi_araddr == `SSF_OFF_STATUS
        |=> s_axi_rdata[15:4] == 12'h0 && s_axi_rdata[31:17] == 15'h0)
        else $error("unused status bits set");
    unmapped_read_a: assert property (ar_go && s_axi_araddr == 8'h30
        |=> s_axi_rresp == `SSF_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    irq_reset_a: assert property ($fell(reset) |-> !irq)
        else $error("interrupt high after reset");
endmodule

bind ssf_status ssf_status_chk ssf_status_chk_inst (.*);

// *** testbench/testbench.sv ***
// self-checking bench for the spi status flag block
// assumes the design header on the include path and a 20 mhz clock
`include "ssf_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    reg clock = 0;
    reg reset = 1;
    reg [7:0] awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0, rd;
    reg [3:0] wstrb = 0;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg dtx = 0, drx = 0, ddone = 0, dlast = 0;
    reg [1:0] rs;
    wire awready, wready, bvalid, arready, rvalid, irq, spi_clk;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer failures = 0, compares = 0, i;

    ssf_status ssf_status_inst (.clock(clock), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .spi_clk(spi_clk),
        .dma_tx_done(dtx), .dma_rx_done(drx), .desc_done(ddone),
        .desc_last(dlast), .irq(irq));
    ssf_spi_model ssf_spi_model_inst (.spi_clk(spi_clk));

    initial forever #25 clock = ~clock;

    task close_out;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask

    // interrupt is registered: look half a cycle after the edge
    task chk_irq(input exp);
        begin
            @(negedge clock);
            chk({31'h0, irq}, {31'h0, exp});
        end
    endtask

    // one bus transfer; readies sampled mid-cycle, stable until next edge
    task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        integer n;
        reg ah, wh, qh, bh;
        begin
            @(posedge clock);
            awaddr <= a;
            araddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= w;
            wvalid <= w;
            bready <= w;
            arvalid <= !w;
            rready <= !w;
            bh = 0;
            for (n = 0; n < 100 && !bh; n = n + 1) begin
                @(negedge clock);
                ah = awvalid & awready;
                wh = wvalid & wready;
                qh = arvalid & arready;
                bh = (bready & bvalid) | (rready & rvalid);
                rd = rdata;
                rs = w ? bresp : rresp;
                @(posedge clock);
                if (ah) awvalid <= 1'b0;
                if (wh) wvalid <= 1'b0;
                if (qh) arvalid <= 1'b0;
                if (bh) bready <= 1'b0;
                if (bh) rready <= 1'b0;
            end
            if (!bh) begin
                failures = failures + 1;
                $display("BAD %0t bus wait ran out", $time);
                close_out;
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task rdc(input [7:0] a, input [31:0] exp);
        begin
            bus(1'b0, a, 32'h0, 4'h0);
            chk(rd, exp);
        end
    endtask

    task pulse(input [3:0] p);
        begin
            @(posedge clock);
            {dlast, ddone, drx, dtx} <= p;
            @(posedge clock);
            {dlast, ddone, drx, dtx} <= 4'h0;
        end
    endtask

    // link edges need a few cycles through the synchroniser
    task frame(input integer n);
        begin
            ssf_spi_model_inst.send_bits(n);
            repeat (8) @(posedge clock);
        end
    endtask

    task t_regs;
        begin
            rdc(`SSF_OFF_STATUS, 32'h0);
            rdc(`SSF_OFF_COUNT, 32'h0);
            rdc(`SSF_OFF_IEN, 32'h0);
            chk_irq(1'b0);
            bus(1'b1, 8'h30, 32'h0, 4'hf);
            chk({30'h0, rs}, 32'h2);
            rdc(8'h30, 32'h0);
            chk({30'h0, rs}, 32'h2);
            $display("test regs done");
        end
    endtask

    task t_fill;
        begin
            bus(1'b1, `SSF_OFF_TXDATA, 32'h0, 4'h1);
            rdc(`SSF_OFF_COUNT, 32'h1);
            bus(1'b1, `SSF_OFF_TXDATA, 32'h0, 4'h3);
            rdc(`SSF_OFF_COUNT, 32'h3);
            for (i = 0; i < 15; i = i + 1)
                bus(1'b1, `SSF_OFF_TXDATA, 32'h0, 4'hf);
            rdc(`SSF_OFF_COUNT, 32'h3f);
            bus(1'b1, `SSF_OFF_TXDATA, 32'h0, 4'h3);
            rdc(`SSF_OFF_COUNT, 32'h3f);
            rdc(`SSF_OFF_STATUS, 32'h4);
            wr(`SSF_OFF_STATUS, 32'h0);
            rdc(`SSF_OFF_STATUS, 32'h4);
            wr(`SSF_OFF_STATUS, 32'h4);
            rdc(`SSF_OFF_STATUS, 32'h0);
            wr(`SSF_OFF_COUNT, 32'hffffffff);
            rdc(`SSF_OFF_COUNT, 32'h3f);
            bus(1'b0, `SSF_OFF_RXDATA, 32'h0, 4'h0);
            rdc(`SSF_OFF_STATUS, 32'h8);
            wr(`SSF_OFF_STATUS, 32'h8);
            $display("test fill done");
        end
    endtask

    task t_manual;
        begin
            wr(`SSF_OFF_IEN, 32'h1);
            wr(`SSF_OFF_CTRL, 32'h00020001);
            rdc(`SSF_OFF_STATUS, 32'h10000);
            frame(16);
            rdc(`SSF_OFF_STATUS, 32'h1);
            rdc(`SSF_OFF_COUNT, 32'h0002003d);
            chk_irq(1'b1);
            wr(`SSF_OFF_IEN, 32'h0);
            chk_irq(1'b0);
            wr(`SSF_OFF_IEN, 32'h1);
            wr(`SSF_OFF_STATUS, 32'h1);
            chk_irq(1'b0);
            wr(`SSF_OFF_IEN, 32'h0);
            bus(1'b0, `SSF_OFF_RXDATA, 32'h0, 4'h0);
            bus(1'b0, `SSF_OFF_RXDATA, 32'h0, 4'h0);
            rdc(`SSF_OFF_COUNT, 32'h3d);
            $display("test manual done");
        end
    endtask

    task t_dma;
        begin
            wr(`SSF_OFF_CTRL, 32'h65);
            pulse(4'h1);
            rdc(`SSF_OFF_STATUS, 32'h10000);
            pulse(4'h2);
            rdc(`SSF_OFF_STATUS, 32'h3);
            wr(`SSF_OFF_STATUS, 32'h3);
            wr(`SSF_OFF_CTRL, 32'h0d);
            pulse(4'h4);
            rdc(`SSF_OFF_STATUS, 32'h10002);
            wr(`SSF_OFF_STATUS, 32'h2);
            pulse(4'hc);
            rdc(`SSF_OFF_STATUS, 32'h3);
            wr(`SSF_OFF_STATUS, 32'h3);
            wr(`SSF_OFF_CTRL, 32'h09);
            pulse(4'hc);
            rdc(`SSF_OFF_STATUS, 32'h1);
            wr(`SSF_OFF_STATUS, 32'h1);
            wr(`SSF_OFF_CTRL, 32'h00010035);
            frame(8);
            rdc(`SSF_OFF_STATUS, 32'h3);
            wr(`SSF_OFF_STATUS, 32'h3);
            $display("test dma done");
        end
    endtask

    task t_stop;
        begin
            wr(`SSF_OFF_CTRL, 32'h1);
            fork
                frame(8);
                begin
                    repeat (12) @(posedge clock);
                    wr(`SSF_OFF_CTRL, 32'h2);
                    rdc(`SSF_OFF_STATUS, 32'h10000);
                end
            join
            rdc(`SSF_OFF_STATUS, 32'h1);
            wr(`SSF_OFF_STATUS, 32'h1);
            wr(`SSF_OFF_CTRL, 32'h1);
            wr(`SSF_OFF_CTRL, 32'h2);
            rdc(`SSF_OFF_STATUS, 32'h1);
            $display("test stop done");
        end
    endtask

    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        t_regs;
        t_fill;
        t_manual;
        t_dma;
        t_stop;
        close_out;
    end
endmodule

// *** verilog/ssf_regs.vh ***
// register map and field layout of the spi status and fill count block
// assumes a 32-bit axi4-lite slave decoding the low byte address bits
`ifndef SSF_REGS_VH
`define SSF_REGS_VH

`define SSF_ADDR_W 8
`define SSF_OFF_CTRL 8'h00
`define SSF_OFF_STATUS 8'h10
`define SSF_OFF_COUNT 8'h14
`define SSF_OFF_IEN 8'h18
`define SSF_OFF_TXDATA 8'h20
`define SSF_OFF_RXDATA 8'h24

// control register fields
`define SSF_CTRL_START 0
`define SSF_CTRL_STOP 1
`define SSF_CTRL_DMA_EN 2
`define SSF_CTRL_DESC_EN 3
`define SSF_CTRL_CLOSE_EN 4
`define SSF_CTRL_TX_DMA 5
`define SSF_CTRL_RX_DMA 6
`define SSF_CTRL_LEN_LSB 16
`define SSF_CTRL_LEN_MSB 31
`define SSF_CTRL_RESET 32'h00000000

// status register fields
`define SSF_ST_XFER_DONE 0
`define SSF_ST_DMA_DONE 1
`define SSF_ST_TX_OVF 2
`define SSF_ST_RX_UNF 3
`define SSF_ST_ACTIVE 16
`define SSF_FLAGS_RESET 4'h0

// fill count fields
`define SSF_CNT_TX_LSB 0
`define SSF_CNT_TX_MSB 15
`define SSF_CNT_RX_LSB 16
`define SSF_CNT_RX_MSB 31
`define SSF_CNT_RESET 16'h0000
`define SSF_IEN_RESET 4'h0

// index of the last bit in a transferred unit (eight bits per unit)
`define SSF_UNIT_BITS 3'h7

`define SSF_RESP_OKAY 2'b00
`define SSF_RESP_SLVERR 2'b10

`endif

// *** verilog/ssf_status.v ***
// spi master status flags, completion logic and buffer fill counters
// assumes axi4-lite master on clock, dma and descriptor pulses on clock,
// and the serial clock arriving from the shifter as an unsynchronised pin
//
// Register access over AXI4-Lite was decided locally.
`include "ssf_regs.vh"

module ssf_status #(
    parameter TX_DEPTH = 16'h0040,
    parameter RX_DEPTH = 16'h0040
) (
    // clock and reset
    input wire clock,
    input wire reset,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // serial link clock from the shifter
    input wire spi_clk,
    // dma controller completion pulses
    input wire dma_tx_done,
    input wire dma_rx_done,
    // descriptor sequencer completion
    input wire desc_done,
    input wire desc_last,
    // interrupt
    output wire irq
);

    // write channel holding
    reg aw_hold_ff, w_hold_ff;
    reg [7:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;

    // registers
    reg [31:0] ctrl_ff;
    reg [3:0] flags_ff, ien_ff;
    reg [15:0] tx_cnt_ff, rx_cnt_ff;
    reg active_ff, stop_ff, irq_ff;

    // link side
    reg sck_s1_ff, sck_s2_ff, sck_s3_ff, sck_st_ff;
    reg [2:0] bit_cnt_ff;
    reg [15:0] unit_cnt_ff;
    reg dma_tx_seen_ff, dma_rx_seen_ff;

    wire wr_fire, rd_fire, wr_status, wr_ctrl, wr_ien, wr_tx, rd_rx;
    wire tx_overflow, rx_underflow, sck_rise, byte_done, rx_put, tx_take;
    wire dma_mode, desc_mode, len_hit, spi_close, stop_now;
    wire tx_side_done, rx_side_done, dma_all_done, dma_set, xfer_set;
    wire [2:0] wr_nbytes;
    wire [16:0] tx_sum;
    wire [3:0] flag_set, flag_clr;

    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;
    reg [15:0] nxt_tx_cnt, nxt_rx_cnt;

    // one write at a time: hold each channel until the response leaves
    assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold_ff & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    assign wr_fire = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;

    assign wr_ctrl = wr_fire & (aw_addr_ff == `SSF_OFF_CTRL);
    assign wr_status = wr_fire & (aw_addr_ff == `SSF_OFF_STATUS);
    assign wr_ien = wr_fire & (aw_addr_ff == `SSF_OFF_IEN);
    assign wr_tx = wr_fire & (aw_addr_ff == `SSF_OFF_TXDATA);
    assign rd_rx = rd_fire & (s_axi_araddr == `SSF_OFF_RXDATA);

    always @(posedge clock) begin
        if (reset) begin
            aw_hold_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_hold_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_hold_ff <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSF_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_ctrl | wr_status | wr_ien | wr_tx |
                (aw_addr_ff == `SSF_OFF_COUNT) |
                (aw_addr_ff == `SSF_OFF_RXDATA)) begin
                s_axi_bresp <= `SSF_RESP_OKAY;
            end else begin
                s_axi_bresp <= `SSF_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read mux
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `SSF_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            `SSF_OFF_CTRL: begin
                nxt_rdata = {ctrl_ff[31:16], 9'h000, ctrl_ff[6:2], 2'b00};
            end
            `SSF_OFF_STATUS: begin
                nxt_rdata = 32'h00000000;
                nxt_rdata[`SSF_ST_ACTIVE] = active_ff;
                nxt_rdata[3:0] = flags_ff;
            end
            `SSF_OFF_COUNT: begin
                nxt_rdata = {rx_cnt_ff, tx_cnt_ff};
            end
            `SSF_OFF_IEN: begin
                nxt_rdata = {28'h0000000, ien_ff};
            end
            `SSF_OFF_TXDATA: begin
                nxt_rdata = 32'h00000000;
            end
            `SSF_OFF_RXDATA: begin
                nxt_rdata = 32'h00000000;
            end
            default: begin
                nxt_rresp = `SSF_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SSF_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control and interrupt enable
    always @(posedge clock) begin
        if (reset) begin
            ctrl_ff <= `SSF_CTRL_RESET;
            ien_ff <= `SSF_IEN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= {w_data_ff[31:16], 9'h000, w_data_ff[6:2],
                    2'b00};
            end
            if (wr_ien) begin
                ien_ff <= w_data_ff[3:0];
            end
        end
    end

    assign dma_mode = ctrl_ff[`SSF_CTRL_DMA_EN];
    assign desc_mode = ctrl_ff[`SSF_CTRL_DESC_EN];

    // three-stage pin sampling; state moves once stages two and three agree
    always @(posedge clock) begin
        if (reset) begin
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_s3_ff <= 1'b0;
            sck_st_ff <= 1'b0;
        end else begin
            sck_s1_ff <= spi_clk;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff;
            if (sck_s2_ff == sck_s3_ff) begin
                sck_st_ff <= sck_s3_ff;
            end
        end
    end

    assign sck_rise = (sck_s2_ff == sck_s3_ff) & sck_s3_ff & ~sck_st_ff;
    assign byte_done = active_ff & sck_rise &
        (bit_cnt_ff == `SSF_UNIT_BITS);

    // each finished byte is one unit: it leaves tx unless tx is empty and lands in rx unless rx is full
    assign tx_take = byte_done & (tx_cnt_ff != 16'h0000);
    assign rx_put = byte_done & (rx_cnt_ff != RX_DEPTH);

    assign len_hit = byte_done &
        ((unit_cnt_ff + 16'h0001) ==
        ctrl_ff[`SSF_CTRL_LEN_MSB:`SSF_CTRL_LEN_LSB]);
    // spi side closes its own dma transfer at the programmed length
    assign spi_close = ctrl_ff[`SSF_CTRL_CLOSE_EN] & len_hit;
    assign tx_side_done = dma_tx_seen_ff | dma_tx_done | spi_close;
    assign rx_side_done = dma_rx_seen_ff | dma_rx_done | spi_close;
    // a direction not in use counts as done
    assign dma_all_done = active_ff & dma_mode & ~desc_mode &
        (ctrl_ff[`SSF_CTRL_TX_DMA] | ctrl_ff[`SSF_CTRL_RX_DMA]) &
        (tx_side_done | ~ctrl_ff[`SSF_CTRL_TX_DMA]) &
        (rx_side_done | ~ctrl_ff[`SSF_CTRL_RX_DMA]);

    // halt waits for a byte boundary; between bytes it ends at once
    assign stop_now = active_ff & stop_ff &
        ((bit_cnt_ff == 3'h0 & ~sck_rise) | byte_done);

    // dma-done only meaningful with dma enabled
    assign dma_set = dma_all_done |
        (dma_mode & desc_mode & desc_done);
    assign xfer_set = (active_ff & ~dma_mode & ~desc_mode & len_hit) |
        dma_all_done |
        (desc_mode & desc_done & desc_last) |
        stop_now;

    always @(posedge clock) begin
        if (reset) begin
            active_ff <= 1'b0;
            stop_ff <= 1'b0;
            bit_cnt_ff <= 3'h0;
            unit_cnt_ff <= 16'h0000;
            dma_tx_seen_ff <= 1'b0;
            dma_rx_seen_ff <= 1'b0;
        end else begin
            if (xfer_set) begin
                active_ff <= 1'b0;
            end else if (wr_ctrl & w_data_ff[`SSF_CTRL_START]) begin
                active_ff <= 1'b1;
            end
            if (xfer_set | ~active_ff) begin
                stop_ff <= 1'b0;
            end else if (wr_ctrl & w_data_ff[`SSF_CTRL_STOP]) begin
                stop_ff <= 1'b1;
            end
            if (~active_ff) begin
                bit_cnt_ff <= 3'h0;
            end else if (sck_rise) begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (~active_ff) begin
                unit_cnt_ff <= 16'h0000;
            end else if (byte_done) begin
                unit_cnt_ff <= unit_cnt_ff + 16'h0001;
            end
            // remember the first direction to finish until the other does
            if (~active_ff | dma_all_done) begin
                dma_tx_seen_ff <= 1'b0;
                dma_rx_seen_ff <= 1'b0;
            end else begin
                dma_tx_seen_ff <= tx_side_done;
                dma_rx_seen_ff <= rx_side_done;
            end
        end
    end

    // transmit byte count from the write strobes
    assign wr_nbytes = {2'b00, w_strb_ff[0]} + {2'b00, w_strb_ff[1]} +
        {2'b00, w_strb_ff[2]} + {2'b00, w_strb_ff[3]};
    assign tx_sum = {1'b0, tx_cnt_ff} + {14'h0000, wr_nbytes};
    // overflowing write is dropped whole, so count never passes depth
    assign tx_overflow = wr_tx & (tx_sum > {1'b0, TX_DEPTH[15:0]});
    assign rx_underflow = rd_rx & (rx_cnt_ff == 16'h0000);

    always @* begin
        nxt_tx_cnt = tx_cnt_ff;
        if (wr_tx & ~tx_overflow) begin
            nxt_tx_cnt = tx_sum[15:0];
        end
        if (tx_take) begin
            nxt_tx_cnt = nxt_tx_cnt - 16'h0001;
        end
        nxt_rx_cnt = rx_cnt_ff;
        if (rx_put) begin
            nxt_rx_cnt = nxt_rx_cnt + 16'h0001;
        end
        if (rd_rx & ~rx_underflow) begin
            nxt_rx_cnt = nxt_rx_cnt - 16'h0001;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            tx_cnt_ff <= `SSF_CNT_RESET;
            rx_cnt_ff <= `SSF_CNT_RESET;
        end else begin
            tx_cnt_ff <= nxt_tx_cnt;
            rx_cnt_ff <= nxt_rx_cnt;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    assign flag_set = {rx_underflow, tx_overflow, dma_set, xfer_set};
    assign flag_clr = wr_status ? w_data_ff[3:0] : 4'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            always @(posedge clock) begin
                if (reset) begin
                    flags_ff[gi] <= 1'b0;
                end else begin
                    flags_ff[gi] <= (flags_ff[gi] & ~flag_clr[gi]) |
                        flag_set[gi];
                end
            end
        end
    endgenerate

    // registered so the pin never glitches while flags and enables change
    always @(posedge clock) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flags_ff & ien_ff);
        end
    end
    assign irq = irq_ff;

endmodule
